// *** hw/idc_port.sv ***
/*
 D-channel contention logic and 2048 kbit/s backplane port of an
 S/T transceiver. Assumes an APB master, a line framer that strobes
 once per D-bit slot, and an HDLC sender that supplies D bits.
*/
// Behaviour
// - While a frame waits, each echoed one advances the priority counter; an echoed zero clears it.
// - Software class picks terminal count 8/9 (high) or 10/11 (low).
// - Internal level picks the exact count within the class.
// - Class dominates; level never moves the count into another class.
// - At terminal count, claim the D-channel by sending the opening flag.
// - On collision stop sending, flag it, drop ack at next frame, recount.
// - After a collision the rest of the frame in the FIFO is discarded.
// - A successful send lowers the internal level within the class.
// - Level returns to high only after the lowered terminal count.
// - In NT mode the timing bit (B4) selects fixed or adaptive timing.
// - An NT leaves reset in fixed timing.
// - Clearing the timing bit returns an NT to fixed timing.
// - Streams run 2048 kbit/s, 32 channels, 8 kHz frame pulse.
// - Sample input on rising edge at 3/4 bit; launch on falling edge.
// - NT takes clock and frame pins as inputs; TE drives them.
// - Only the first four channels carry control, D, B1 and B2.
// - A delayed frame pulse drives the next device in a chain.
// - In star mode all NTs output the shared received 2B+D data.
// - Line-to-backplane always passes; reverse D, B1 and B2 need active or synced state, control always passes.
// - NT slave runs as NT with TE frame and register meanings.
// - An NT copies each received D bit into the outgoing echo bit.
`timescale 1ns/1ns
`default_nettype none
module idc_port
   import idc_pkg::*;
#(
   parameter int C4_HALF = C4_HALF_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   // Straps and link state
   input wire logic term_mode_select_i,
   input wire logic nt_slave_i,
   input wire logic [1:0] link_state_bits_i,
   output logic activation_request_o,
   output logic deactivation_request_o,
   output logic adaptive_timing_o,
   // Backplane pins
   input wire logic bit_clock_i,
   output logic bit_clock_o,
   output logic bit_clock_oe_o,
   input wire logic frame_pulse_i,
   output logic frame_pulse_o,
   output logic frame_pulse_oe_o,
   input wire logic serial_stream_in_i,
   output logic serial_stream_out_o,
   output logic serial_stream_out_oe_o,
   output logic chained_frame_pulse_out_o,
   input wire logic star_i,
   output logic star_o,
   output logic star_oe_o,
   // Line framer side
   input wire logic [7:0] status_chan_i,
   input wire logic [7:0] line_rx_d_i,
   input wire logic [7:0] line_rx_b1_i,
   input wire logic [7:0] line_rx_b2_i,
   output logic [7:0] ctrl_chan_o,
   output logic [7:0] line_tx_d_o,
   output logic [7:0] line_tx_b1_o,
   output logic [7:0] line_tx_b2_o,
   input wire logic line_bit_stb_i,
   input wire logic echo_bit_i,
   input wire logic d_rx_bit_i,
   output logic echo_tx_o,
   // HDLC sender side
   input wire logic tx_pending_i,
   input wire logic tx_bit_i,
   input wire logic tx_done_i,
   output logic d_tx_o,
   output logic d_tx_active_o,
   output logic flag_start_o,
   output logic fifo_discard_o,
   output logic d_channel_ack_bit_o
);
   idc_state_t s;
   idc_state_t n;
   logic nt;
   logic te_view;
   logic div_wrap;
   logic rise;
   logic fall;
   logic fp_low;
   logic pass;
   logic access;
   logic [3:0] term;
   logic [8:0] next_c4cnt;

   // Class selects the pair, level picks within it, never across
   function automatic logic [3:0] term_count(input logic low_class,
                                              input logic high_level);
      if (low_class) begin
         term_count = high_level ? TERM_LC_HL : TERM_LC_LL;
      end else begin
         term_count = high_level ? TERM_HC_HL : TERM_HC_LL;
      end
   endfunction

   // Picks the byte launched in one of our own four channels
   function automatic logic [7:0] chan_byte(input logic [4:0] ch,
                                            input logic [7:0] c,
                                            input logic [7:0] d,
                                            input logic [7:0] b1,
                                            input logic [7:0] b2);
      case (ch)
         5'h00: chan_byte = c;
         5'h01: chan_byte = d;
         5'h02: chan_byte = b1;
         default: chan_byte = b2;
      endcase
   endfunction

   // Mode decode; NT slave keeps NT pins but TE framing meaning
   assign nt = s.mode_s2;
   assign te_view = !s.mode_s2 | s.slave_s2;
   assign term = term_count(s.class_low, s.level_high);
   assign access = psel_i & penable_i & !s.pready;

   // Bit clock edges: sampled pin in NT, own divider in TE
   assign div_wrap = (s.div == 8'(C4_HALF - 1));
   assign rise = nt ? (s.c4_s2 & !s.c4_s3) : (div_wrap & !s.c4_gen);
   assign fall = nt ? (!s.c4_s2 & s.c4_s3) : (div_wrap & s.c4_gen);
   // Frame pulse seen at a falling edge restarts the frame count
   assign fp_low = nt ? !s.fp_s2 : (s.c4cnt == C4_LAST);
   assign next_c4cnt = fp_low ? 9'h000 : s.c4cnt + 9'h001;

   // Backplane-to-line D, B1 and B2 open only once the link is up; control always passes
   assign pass = te_view ? link_state_bits_i[0]
                         : (link_state_bits_i == 2'b11);

   // Next-state logic for the whole block
   always_comb begin
      logic [7:0] sh;
      logic [7:0] ob;
      logic [4:0] ch;
      logic [8:0] ahead;
      logic [7:0] ab;
      sh = {s.sh_in[6:0], s.sin_s2};
      ob = 8'h00;
      ch = next_c4cnt[8:4];
      ahead = next_c4cnt + 9'h002;
      ab = chan_byte(ahead[8:4], status_chan_i, line_rx_d_i,
                     line_rx_b1_i, line_rx_b2_i);
      n = s;
      n.flag_start = 1'b0;
      n.discard = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;

      // Two-stage synchronisers for all pins from outside
      n.c4_s1 = bit_clock_i;
      n.c4_s2 = s.c4_s1;
      n.c4_s3 = s.c4_s2;
      n.fp_s1 = frame_pulse_i;
      n.fp_s2 = s.fp_s1;
      n.sin_s1 = serial_stream_in_i;
      n.sin_s2 = s.sin_s1;
      n.star_s1 = star_i;
      n.star_s2 = s.star_s1;
      n.mode_s1 = term_mode_select_i;
      n.mode_s2 = s.mode_s1;
      n.slave_s1 = nt_slave_i;
      n.slave_s2 = s.slave_s1;

      // Divider for the bit clock that a TE drives out
      if (div_wrap) begin
         n.div = 8'h00;
         n.c4_gen = !s.c4_gen;
      end else begin
         n.div = s.div + 8'h01;
      end

      // Falling edge: advance count and launch the next bit
      if (fall) begin
         n.c4cnt = next_c4cnt;
         n.cfp = (next_c4cnt != CHAIN_POS);
         n.fp_out = (next_c4cnt != C4_LAST);
         if (next_c4cnt == 9'h000 && s.ack_clr) begin
            n.ack = 1'b0;
            n.ack_clr = 1'b0;
         end
         if (!next_c4cnt[0]) begin
            ob = chan_byte(ch, status_chan_i, line_rx_d_i,
                           line_rx_b1_i, line_rx_b2_i);
            n.sout_oe = (ch < OWN_CHANS);
            n.sout = ob[3'd7 - next_c4cnt[3:1]];
            // Star bit goes out a cell early so the wired value has settled
            n.star_do = (ahead[8:4] != 5'h00 && ahead[8:4] < OWN_CHANS) ?
                        ab[3'd7 - ahead[3:1]] : 1'b1;
            if (s.star_en && nt && ch != 5'h00 && ch < OWN_CHANS) begin
               n.sout = s.star_s2;
            end
         end
      end

      // Rising edge at three quarters of the cell: sample
      if (rise && s.c4cnt[0]) begin
         n.sh_in = sh;
         if (s.c4cnt[3:1] == 3'd7) begin
            case (s.c4cnt[8:4])
               5'h00: n.ctrl_in = sh;
               5'h01: n.tx_d = pass ? sh : IDLE_BYTE;
               5'h02: n.tx_b1 = pass ? sh : IDLE_BYTE;
               5'h03: n.tx_b2 = pass ? sh : IDLE_BYTE;
               default: n.ctrl_in = s.ctrl_in;
            endcase
         end
      end

      // APB slave: answers in the second access cycle
      if (access) begin
         n.pready = 1'b1;
         n.prdata = 32'h0000_0000;
         if (paddr_i == ADDR_CTRL) begin
            if (pwrite_i && pstrb_i[0]) begin
               n.class_low = pwdata_i[CB_CLASS];
               n.ar = pwdata_i[CB_AR];
               n.dr = pwdata_i[CB_DR];
               n.star_en = pwdata_i[CB_STAR];
               n.timing = pwdata_i[CB_TIMING];
            end else if (!pwrite_i) begin
               n.prdata[CB_CLASS] = s.class_low;
               n.prdata[CB_AR] = s.ar;
               n.prdata[CB_DR] = s.dr;
               n.prdata[CB_STAR] = s.star_en;
               n.prdata[CB_TIMING] = s.timing;
            end
         end else if (paddr_i == ADDR_STAT) begin
            if (pwrite_i && pstrb_i[0] && pwdata_i[SB_COLL]) begin
               n.coll = 1'b0;
            end else if (!pwrite_i) begin
               n.prdata[SB_COLL] = s.coll;
               n.prdata[SB_ACK] = s.ack;
               n.prdata[SB_LEVEL] = s.level_high;
               n.prdata[SB_CNT +: 4] = s.cnt;
               n.prdata[SB_LINK +: 2] = link_state_bits_i;
               n.prdata[SB_ADAPT] = nt & s.timing;
            end
         end else begin
            n.pslverr = 1'b1; // Unmapped address
         end
      end

      // D-channel slot: echo, contention and collision watch
      if (line_bit_stb_i) begin
         n.echo_tx = nt ? d_rx_bit_i : 1'b1;
         case (s.dst)
            DS_COUNT: begin
               n.d_tx = 1'b1;
               // Count only when a frame waits and we are idle
               if (tx_pending_i) begin
                  if (!echo_bit_i) begin
                     n.cnt = 4'h0;
                  end else if (s.cnt + 4'h1 >= term) begin
                     n.dst = DS_SEND;
                     n.cnt = 4'h0;
                     n.flag_start = 1'b1;
                     n.d_tx = tx_bit_i;
                     n.ack = 1'b1;
                     n.ack_clr = 1'b0;
                     n.level_high = 1'b1;
                  end else begin
                     n.cnt = s.cnt + 4'h1;
                  end
               end
            end
            DS_SEND: begin
               if (echo_bit_i != s.d_tx) begin
                  // Set wins over a clear in this same cycle
                  n.dst = DS_COUNT;
                  n.d_tx = 1'b1;
                  n.coll = 1'b1;
                  n.ack_clr = 1'b1;
                  n.cnt = 4'h0;
                  n.discard = 1'b1;
               end else if (tx_done_i) begin
                  n.dst = DS_COUNT;
                  n.d_tx = 1'b1;
                  n.level_high = 1'b0;
               end else begin
                  n.d_tx = tx_bit_i;
               end
            end
            default: begin
               n.dst = DS_COUNT;
               n.d_tx = 1'b1;
            end
         endcase
      end
   end

   // State register; constants only under reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '0;
         s.c4_s1 <= 1'b1;
         s.c4_s2 <= 1'b1;
         s.c4_s3 <= 1'b1;
         s.fp_s1 <= 1'b1;
         s.fp_s2 <= 1'b1;
         s.star_s1 <= 1'b1;
         s.star_s2 <= 1'b1;
         s.fp_out <= 1'b1;
         s.cfp <= 1'b1;
         s.star_do <= 1'b1;
         s.sout <= 1'b1;
         s.tx_d <= IDLE_BYTE;
         s.tx_b1 <= IDLE_BYTE;
         s.tx_b2 <= IDLE_BYTE;
         s.ctrl_in <= IDLE_BYTE;
         s.class_low <= CTRL_RST[CB_CLASS];
         s.timing <= CTRL_RST[CB_TIMING];
         s.level_high <= 1'b1;
         s.dst <= DS_COUNT;
         s.d_tx <= 1'b1;
         s.echo_tx <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // All outputs from state flops only, a few through gates on them
   assign pready_o = s.pready;
   assign prdata_o = s.prdata;
   assign pslverr_o = s.pslverr;
   assign activation_request_o = s.ar;
   assign deactivation_request_o = s.dr;
   assign adaptive_timing_o = s.timing & s.mode_s2;
   assign bit_clock_o = s.c4_gen;
   assign bit_clock_oe_o = !s.mode_s2;
   assign frame_pulse_o = s.fp_out;
   assign frame_pulse_oe_o = !s.mode_s2;
   assign serial_stream_out_o = s.sout;
   assign serial_stream_out_oe_o = s.sout_oe;
   assign chained_frame_pulse_out_o = s.cfp;
   assign star_o = s.star_do;
   assign star_oe_o = s.star_en & s.sout_oe & !s.star_do;
   assign ctrl_chan_o = s.ctrl_in;
   assign line_tx_d_o = s.tx_d;
   assign line_tx_b1_o = s.tx_b1;
   assign line_tx_b2_o = s.tx_b2;
   assign echo_tx_o = s.echo_tx;
   assign d_tx_o = s.d_tx;
   assign d_tx_active_o = (s.dst == DS_SEND);
   assign flag_start_o = s.flag_start;
   assign fifo_discard_o = s.discard;
   assign d_channel_ack_bit_o = s.ack;
endmodule
`default_nettype wire

// *** hw/idc_pkg.sv ***
/*
 Constants, register map and state type for the D-channel access and
 backplane port block. Assumes a 125 MHz system clock.
*/
package idc_pkg;
   // Register byte addresses on APB
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   // Control register bit positions
   localparam int CB_CLASS = 0;
   localparam int CB_AR = 1;
   localparam int CB_DR = 2;
   localparam int CB_STAR = 3;
   localparam int CB_TIMING = 4;
   // Status register bit positions
   localparam int SB_COLL = 0;
   localparam int SB_ACK = 1;
   localparam int SB_LEVEL = 2;
   localparam int SB_CNT = 4;
   localparam int SB_LINK = 8;
   localparam int SB_ADAPT = 10;
   // Terminal counts: class high/low, level high/low
   localparam logic [3:0] TERM_HC_HL = 4'h8;
   localparam logic [3:0] TERM_HC_LL = 4'h9;
   localparam logic [3:0] TERM_LC_HL = 4'hA;
   localparam logic [3:0] TERM_LC_LL = 4'hB;
   // Frame geometry in bit clock periods (two per bit, 256 bits)
   localparam logic [8:0] C4_LAST = 9'h1FF;
   localparam logic [8:0] CHAIN_POS = 9'h03F;
   localparam logic [4:0] OWN_CHANS = 5'h04;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // Bit clock generation for terminal mode
   localparam int CLK_HZ = 125000000;
   localparam int C4_HZ = 4096000;
   localparam int C4_HALF_CYC = CLK_HZ / (2 * C4_HZ);

   typedef enum logic [1:0] {
      DS_COUNT = 2'b00,
      DS_SEND = 2'b01
   } idc_dst_t;

   typedef struct packed {
      logic c4_s1, c4_s2, c4_s3;
      logic fp_s1, fp_s2;
      logic sin_s1, sin_s2;
      logic star_s1, star_s2;
      logic mode_s1, mode_s2;
      logic slave_s1, slave_s2;
      logic [7:0] div;
      logic c4_gen;
      logic fp_out;
      logic [8:0] c4cnt;
      logic [7:0] sh_in;
      logic [7:0] ctrl_in, tx_d, tx_b1, tx_b2;
      logic sout, sout_oe, star_do, cfp;
      logic class_low, ar, dr, star_en, timing;
      logic coll, ack, ack_clr, level_high;
      logic [3:0] cnt;
      idc_dst_t dst;
      logic flag_start, discard, d_tx, echo_tx;
      logic pready, pslverr;
      logic [31:0] prdata;
   } idc_state_t;
endpackage

// *** verification/idc_port_sva.sv ***
/*
 Checker for idc_port, bound to every instance.
 Assumes straps change only while the bus and the slot strobe are idle.
*/
`timescale 1ns/1ns
`default_nettype none
module idc_port_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic term_mode_select_i,
   input wire logic bit_clock_oe_o,
   input wire logic frame_pulse_oe_o,
   input wire logic line_bit_stb_i,
   input wire logic echo_bit_i,
   input wire logic d_rx_bit_i,
   input wire logic tx_pending_i,
   input wire logic echo_tx_o,
   input wire logic d_tx_o,
   input wire logic d_tx_active_o,
   input wire logic flag_start_o,
   input wire logic fifo_discard_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Bus answers after one wait state, for one cycle
   apb_answer_a: assert property (psel_i && penable_i && !pready_o
      |=> pready_o) else $error("late answer");
   apb_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("long answer");
   apb_error_a: assert property (pslverr_o |-> pready_o)
      else $error("stray error");
   // A claim needs an echoed one on a slot with a frame waiting
   claim_cause_a: assert property (
      flag_start_o |-> d_tx_active_o && $past(line_bit_stb_i) &&
      $past(echo_bit_i) && $past(tx_pending_i)) else $error("bad claim");
   claim_pulse_a: assert property (
      $rose(d_tx_active_o) |-> flag_start_o) else $error("silent claim");
   // Collision is judged against the bit on the line, and wins
   coll_react_a: assert property (
      d_tx_active_o && line_bit_stb_i && (echo_bit_i != d_tx_o)
      |=> fifo_discard_o && !d_tx_active_o) else $error("missed clash");
   coll_cause_a: assert property (
      fifo_discard_o |-> $past(d_tx_active_o) && $past(line_bit_stb_i))
      else $error("bad discard");
   line_idle_a: assert property (!d_tx_active_o |-> d_tx_o)
      else $error("line not released");
   echo_copy_a: assert property (
      line_bit_stb_i && !bit_clock_oe_o |=> echo_tx_o == $past(d_rx_bit_i))
      else $error("echo wrong");
   pin_nt_a: assert property (term_mode_select_i [*4] |->
      !bit_clock_oe_o && !frame_pulse_oe_o) else $error("nt drives pins");
   pin_te_a: assert property (!term_mode_select_i [*4] |->
      bit_clock_oe_o && frame_pulse_oe_o) else $error("te pins idle");
   cover property (flag_start_o);
   cover property (fifo_discard_o);
   cover property (pready_o && pslverr_o);
endmodule
bind idc_port idc_port_chk u_chk (.clk_i, .rst_n_i, .psel_i, .penable_i,
   .pready_o, .pslverr_o, .term_mode_select_i, .bit_clock_oe_o,
   .frame_pulse_oe_o, .line_bit_stb_i, .echo_bit_i, .d_rx_bit_i,
   .tx_pending_i, .echo_tx_o, .d_tx_o, .d_tx_active_o, .flag_start_o,
   .fifo_discard_o);
`default_nettype wire

// *** verification/idc_bp_model.sv ***
/*
 Backplane partner: bit clock, frame pulse and channel 0..3 traffic,
 capturing what the block sends. Assumes the bench routes its clock
 and pulse to the pins only while the block leaves them undriven.
*/
`timescale 1ns/1ns
`default_nettype none
module idc_bp_model (
   input wire logic sout_i,
   input wire logic sout_oe_i,
   output logic bck_o,
   output logic fp_n_o,
   output logic sin_o,
   output logic [8:0] cnt_o,
   output logic [31:0] rx_o
);
   localparam logic [31:0] TX_WORD = 32'hC35A_963C;
   logic [8:0] nx;
   assign nx = cnt_o + 9'h001;
   initial begin
      bck_o = 1'b1;
      fp_n_o = 1'b1;
      sin_o = 1'b1;
      cnt_o = 9'h000;
      rx_o = 32'h0000_0000;
   end
   // Backplane timebase runs free, as a system clock does
   always #80 bck_o = ~bck_o;
   // Falling edge: 512 periods a frame, launch at cell start
   always @(negedge bck_o) begin
      cnt_o <= nx;
      if (nx[0] == 1'b0) begin
         // Outside our channels a toggling pattern, never a held value
         sin_o <= (nx < 9'h040) ? TX_WORD[5'd31 - nx[5:1]] : nx[1];
      end
   end
   // Rising edge: pulse spans the frame boundary; sample at 3/4 cell
   always @(posedge bck_o) begin
      fp_n_o <= (cnt_o != 9'h1FF);
      if (cnt_o[0] && cnt_o < 9'h040 && sout_oe_i) begin
         rx_o <= {rx_o[30:0], sout_i};
      end
   end
endmodule
`default_nettype wire

// *** verification/tb_isdn_d_channel_access_tdm_port.sv ***
/*
 Bench for idc_port: APB tasks, slot strobes, backplane partner.
 Assumes one APB wait state and the partner clock only in NT mode.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_isdn_d_channel_access_tdm_port;
   import idc_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [3:0] pstrb_i = 4'hF;
   logic [1:0] link_state_bits_i = 2'b00;
   logic nt_slave_i = 1'b0, term_mode_select_i = 1'b0;
   logic line_bit_stb_i = 1'b0, echo_bit_i = 1'b1, d_rx_bit_i = 1'b1;
   logic tx_pending_i = 1'b0, tx_bit_i = 1'b1, tx_done_i = 1'b0;
   logic [7:0] status_chan_i = 8'hA5, line_rx_d_i = 8'h81;
   logic [7:0] line_rx_b1_i = 8'h42, line_rx_b2_i = 8'h24;
   logic pready_o, pslverr_o, activation_request_o, deactivation_request_o;
   logic adaptive_timing_o, bit_clock_o, bit_clock_oe_o, frame_pulse_o;
   logic frame_pulse_oe_o, serial_stream_out_o, serial_stream_out_oe_o;
   logic chained_frame_pulse_out_o, star_o, star_oe_o, echo_tx_o, d_tx_o;
   logic d_tx_active_o, flag_start_o, fifo_discard_o, d_channel_ack_bit_o;
   logic [31:0] prdata_o, m_rx, q;
   logic [7:0] ctrl_chan_o, line_tx_d_o, line_tx_b1_o, line_tx_b2_o;
   logic bit_clock_i, frame_pulse_i, star_i, serial_stream_in_i;
   logic m_bck, m_fp_n, err, got;
   logic [8:0] m_cnt;
   int n_fail = 0, compares = 0, cyc = 0, t0 = 0;
   // Pins go to whichever side drives them; star line has a pull-up
   assign bit_clock_i = bit_clock_oe_o ? bit_clock_o : m_bck;
   assign frame_pulse_i = frame_pulse_oe_o ? frame_pulse_o : m_fp_n;
   assign star_i = !star_oe_o;
   idc_port #(.C4_HALF(2)) uut (.*);
   idc_bp_model partner (.sout_i(serial_stream_out_o),
      .sout_oe_i(serial_stream_out_oe_o), .bck_o(m_bck), .fp_n_o(m_fp_n),
      .sin_o(serial_stream_in_i), .cnt_o(m_cnt), .rx_o(m_rx));
   always #4 clk_i = ~clk_i;
   // Six frames at most are waited for; past nearly nine (90000 cycles) the run is hung
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 90000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string what);
      compares++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   task automatic settle();
      @(posedge clk_i);
   endtask
   // One APB transfer; an idle edge first keeps drives apart
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // Only the global timeout ends this wait
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      q = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // One D-bit slot; got tells whether it claimed the channel
   task automatic stb(input logic e, input logic done);
      @(posedge clk_i);
      line_bit_stb_i <= 1'b1;
      echo_bit_i <= e;
      d_rx_bit_i <= !e;
      tx_done_i <= done;
      @(posedge clk_i);
      line_bit_stb_i <= 1'b0;
      tx_done_i <= 1'b0;
      @(posedge clk_i);
      got = flag_start_o;
   endtask
   task automatic claim(input int exp);
      int n;
      n = 0;
      got = 1'b0;
      while (got !== 1'b1 && n < 16) begin
         stb(1'b1, 1'b0);
         n++;
      end
      chk(n == exp, "claim count");
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0000_0000);
      chk(q === CTRL_RST, "ctrl reset");
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      chk(q === 32'h0000_0004, "stat reset");
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(err === 1'b1 && q === 32'h0000_0000, "unmapped");
      // TE makes its own frame: 512 bit clock periods of 2*C4_HALF cycles
      @(negedge frame_pulse_o);
      t0 = cyc;
      @(negedge frame_pulse_o);
      chk(cyc - t0 == (int'(C4_LAST) + 1) * 4, "te frame");
      apb(1'b1, ADDR_CTRL, 32'h0000_0014);
      settle();
      chk(adaptive_timing_o === 1'b0, "te timing");
      term_mode_select_i <= 1'b1;
      repeat (6) settle();
      chk(adaptive_timing_o === 1'b1, "nt timing");
      // Second reset, now as NT: timing must come back fixed
      rst_n_i <= 1'b0;
      repeat (8) settle();
      rst_n_i <= 1'b1;
      repeat (4) settle();
      chk(adaptive_timing_o === 1'b0, "nt reset");
      apb(1'b1, ADDR_CTRL, 32'h0000_0004);
      apb(1'b1, ADDR_CTRL, 32'h0000_0014);
      settle();
      chk(deactivation_request_o & adaptive_timing_o, "adaptive");
      apb(1'b1, ADDR_CTRL, 32'h0000_0004);
      settle();
      chk(!adaptive_timing_o & deactivation_request_o &
         !activation_request_o, "fixed");
      // Contention: an echoed zero restarts the count
      tx_pending_i <= 1'b1;
      repeat (5) stb(1'b1, 1'b0);
      stb(1'b0, 1'b0);
      claim(8);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      chk(q[SB_ACK] === 1'b1 && q[SB_LEVEL] === 1'b1, "ack set");
      stb(1'b1, 1'b1);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      chk(q[SB_LEVEL] === 1'b0, "level low");
      claim(9);
      stb(1'b1, 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h0000_0005);
      tx_bit_i <= 1'b0;
      claim(11);
      tx_bit_i <= 1'b1;
      stb(1'b1, 1'b0);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      chk(q[SB_COLL] === 1'b1 && q[SB_ACK] === 1'b1, "collision");
      @(negedge m_fp_n);
      repeat (40) settle();
      apb(1'b1, ADDR_STAT, 32'h0000_0001);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      chk(q[SB_ACK] === 1'b0 && q[SB_COLL] === 1'b0, "ack clear");
      claim(10);
      stb(1'b1, 1'b1);
      // Backplane: link down, only line-to-backplane data and the backplane control channel pass
      repeat (2) @(negedge m_fp_n);
      settle();
      chk(m_rx === 32'hA581_4224, "to backplane");
      chk(line_tx_b1_o === IDLE_BYTE && ctrl_chan_o === 8'hC3, "idle");
      // Star on, fixed timing kept; a lone NT must see its own data back
      apb(1'b1, ADDR_CTRL, 32'h0000_000D);
      link_state_bits_i <= 2'b11;
      repeat (2) @(negedge m_fp_n);
      settle();
      chk({line_tx_d_o, line_tx_b1_o, line_tx_b2_o} === 24'h5A_963C,
         "to line");
      chk(m_rx === 32'hA581_4224, "star share");
      @(negedge chained_frame_pulse_out_o);
      chk(m_cnt === CHAIN_POS, "chain offset");
      print_verdict();
   end
endmodule
`default_nettype wire
